// *** hw/event_line_ctrl.sv ***
// Purpose: External event line controller with nineteen edge detector lines
// Assumes: sys_clk_i is an always-on capture clock, not the peripheral bus clock
// Notes: Configuration arrives as plain inputs from logic on the same clock
`timescale 1ns/100ps
`include "eel_cfg.svh"
module event_line_ctrl
    import eel_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Sources
    input wire pin_vec_t gpio_pins_i,
    input wire logic supply_low_i,
    input wire logic cal_alarm_i,
    input wire logic aux_event_i,
    // Configuration
    input wire sel_bus_t port_sel_i,
    input wire line_vec_t rise_en_i,
    input wire line_vec_t fall_en_i,
    input wire line_vec_t int_en_i,
    input wire line_vec_t evt_en_i,
    input wire line_vec_t pending_clear_i,
    // Requests
    output line_vec_t pending_o,
    output line_vec_t irq_o,
    output line_vec_t event_o,
    output logic wake_o
);
    // Synchroniser stages
    pin_vec_t pin_meta;
    pin_vec_t pin_sync;
    pin_vec_t next_pin_meta;
    pin_vec_t next_pin_sync;
    int_src_t src_meta;
    int_src_t src_sync;
    int_src_t next_src_meta;
    int_src_t next_src_sync;

    // Disarm after reset and select history
    fill_cnt_t fill_cnt;
    fill_cnt_t next_fill_cnt;
    logic fill_busy;
    sel_bus_t sel_prev;
    sel_bus_t next_sel_prev;

    // Line levels and detector results
    logic [`EEL_NUM_EXT-1:0] ext_level;
    logic [`EEL_NUM_EXT-1:0] ext_rearm;
    line_vec_t line_level;
    line_vec_t rearm;
    line_vec_t line_pending;
    line_vec_t line_edge;

    // Request stage
    line_vec_t irq;
    line_vec_t next_irq;
    line_vec_t evt;
    line_vec_t next_evt;
    logic wake;
    logic next_wake;

    // Pin synchronisers, two stages before any logic reads them
    always_comb begin
        next_pin_meta = gpio_pins_i;
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    // Internal source synchronisers
    always_comb begin
        next_src_meta[`EEL_SRC_SUPPLY] = supply_low_i;
        next_src_meta[`EEL_SRC_ALARM] = cal_alarm_i;
        next_src_meta[`EEL_SRC_AUX] = aux_event_i;
        next_src_sync = src_meta;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            src_meta <= '0;
            src_sync <= '0;
        end else begin
            src_meta <= next_src_meta;
            src_sync <= next_src_sync;
        end
    end

    // Hold all lines disarmed until the synchronisers hold real levels
    always_comb begin
        fill_busy = (fill_cnt != `EEL_FILL_CYCLES);
        next_fill_cnt = fill_busy ? fill_cnt_t'(fill_cnt + `EEL_FILL_STEP) : fill_cnt;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            fill_cnt <= `EEL_FILL_RESET;
        end else begin
            fill_cnt <= next_fill_cnt;
        end
    end

    // Select history for the re-arm of a switched line
    always_comb begin
        next_sel_prev = port_sel_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sel_prev <= '0;
        end else begin
            sel_prev <= next_sel_prev;
        end
    end

    // Pin routing onto the external lines
    always_comb begin
        port_sel_t sel;
        port_sel_t old_sel;
        sel = '0;
        old_sel = '0;
        ext_level = '0;
        ext_rearm = '0;
        for (int i = 0; i < `EEL_NUM_EXT; i++) begin
            sel = port_sel_i[i*`EEL_SEL_W +: `EEL_SEL_W];
            old_sel = sel_prev[i*`EEL_SEL_W +: `EEL_SEL_W];
            // Unused port codes route a constant low
            if (int'(sel) < `EEL_NUM_PORTS) begin
                ext_level[i] = pin_sync[int'(sel)*`EEL_PORT_W + i];
            end
            // A select change loads the new pin's level without a false edge
            ext_rearm[i] = fill_busy | (sel != old_sel);
        end
    end

    // Internal sources beside the external lines
    always_comb begin
        line_level = line_vec_t'(ext_level);
        rearm = line_vec_t'(ext_rearm);
        line_level[`EEL_LINE_SUPPLY] = src_sync[`EEL_SRC_SUPPLY];
        line_level[`EEL_LINE_ALARM] = src_sync[`EEL_SRC_ALARM];
        line_level[`EEL_LINE_AUX] = src_sync[`EEL_SRC_AUX];
        rearm[`EEL_LINE_SUPPLY] = fill_busy;
        rearm[`EEL_LINE_ALARM] = fill_busy;
        rearm[`EEL_LINE_AUX] = fill_busy;
    end

    // One detector per line, all on the capture clock
    for (genvar g = 0; g < `EEL_NUM_LINES; g++) begin : g_line
        edge_line u_line (
            .sys_clk_i(sys_clk_i),
            .rstn_i(rstn_i),
            .level_i(line_level[g]),
            .rearm_i(rearm[g]),
            .rise_en_i(rise_en_i[g]),
            .fall_en_i(fall_en_i[g]),
            .int_en_i(int_en_i[g]),
            .clear_i(pending_clear_i[g]),
            .pending_o(line_pending[g]),
            .edge_o(line_edge[g])
        );
    end

    // Masked interrupt forwarding
    always_comb begin
        next_irq = line_pending & int_en_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            irq <= '0;
        end else begin
            irq <= next_irq;
        end
    end

    // Masked event forwarding
    always_comb begin
        next_evt = line_edge & evt_en_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            evt <= '0;
        end else begin
            evt <= next_evt;
        end
    end

    // Wake request, needs no bus clock
    always_comb begin
        next_wake = (|next_irq) | (|next_evt);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wake <= 1'b0;
        end else begin
            wake <= next_wake;
        end
    end

    // Outputs straight from flops
    assign pending_o = line_pending;
    assign irq_o = irq;
    assign event_o = evt;
    assign wake_o = wake;
endmodule

// *** hw/eel_cfg.svh ***
// Purpose: Constants for the external event line controller
// Assumes: One always-running capture clock
// Notes: Included by the package and the design files
`ifndef EEL_CFG_SVH
`define EEL_CFG_SVH
`define EEL_NUM_LINES 19
`define EEL_NUM_EXT 16
`define EEL_NUM_PORTS 7
`define EEL_PORT_W 16
`define EEL_NUM_PINS 112
`define EEL_SEL_W 4
`define EEL_LINE_SUPPLY 16
`define EEL_LINE_ALARM 17
`define EEL_LINE_AUX 18
`define EEL_SRC_SUPPLY 0
`define EEL_SRC_ALARM 1
`define EEL_SRC_AUX 2
`define EEL_NUM_INT_SRC 3
`define EEL_FILL_W 2
`define EEL_FILL_CYCLES 2'h3
`define EEL_FILL_STEP 2'h1
`define EEL_FILL_RESET 2'h0
`endif

// *** hw/eel_pkg.sv ***
// Purpose: Types for the external event line controller
// Assumes: Widths come from eel_cfg.svh
// Notes: Types only
`include "eel_cfg.svh"
package eel_pkg;
    typedef logic [`EEL_NUM_LINES-1:0] line_vec_t;
    typedef logic [`EEL_NUM_PINS-1:0] pin_vec_t;
    typedef logic [`EEL_SEL_W-1:0] port_sel_t;
    typedef logic [`EEL_NUM_EXT*`EEL_SEL_W-1:0] sel_bus_t;
    typedef logic [`EEL_NUM_INT_SRC-1:0] int_src_t;
    typedef logic [`EEL_FILL_W-1:0] fill_cnt_t;
endpackage

// *** hw/edge_line.sv ***
// Purpose: One edge detector line with its pending flag
// Assumes: level_i is already synchronised to sys_clk_i
// Notes: A set in the clearing cycle wins over the clear
`timescale 1ns/100ps
`include "eel_cfg.svh"
module edge_line (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Line input and control
    input wire logic level_i,
    input wire logic rearm_i,
    input wire logic rise_en_i,
    input wire logic fall_en_i,
    input wire logic int_en_i,
    input wire logic clear_i,
    // Results
    output logic pending_o,
    output logic edge_o
);
    logic prev;
    logic pending;
    logic edge_q;
    logic next_prev;
    logic next_pending;
    logic next_edge;
    logic hit;

    always_comb begin
        next_prev = level_i;
        // Selected edge, none while the line is re-arming
        hit = ~rearm_i & ((level_i & ~prev & rise_en_i) | (~level_i & prev & fall_en_i));
        next_edge = hit;
        // Masked lines do not record
        next_pending = (hit & int_en_i) | (pending & ~clear_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prev <= 1'b0;
            pending <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            prev <= next_prev;
            pending <= next_pending;
            edge_q <= next_edge;
        end
    end

    assign pending_o = pending;
    assign edge_o = edge_q;
endmodule

// *** verification/eel_src_model.sv ***
// Purpose: Pin bank and internal sources facing event_line_ctrl
// Assumes: Requests arrive just after a clock edge
// Notes: A pin changes on the edge after its request
`timescale 1ns/100ps
module eel_src_model
    import eel_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Pin request
    input wire logic set_i,
    input wire logic [6:0] idx_i,
    input wire logic val_i,
    input wire int_src_t src_i,
    // Sources
    output pin_vec_t gpio_pins_o,
    output int_src_t int_src_o
);
    pin_vec_t pins = '0;
    always @(posedge sys_clk_i) begin
        if (set_i) begin
            pins[idx_i] <= val_i;
        end
    end
    assign gpio_pins_o = pins;
    assign int_src_o = src_i;
endmodule

// *** verification/event_line_ctrl_chk.sv ***
// Purpose: Port checker for event_line_ctrl
// Assumes: One clock, sync active-low reset
// Notes: Bound to the top module
`timescale 1ns/100ps
module event_line_ctrl_chk
    import eel_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Watched ports
    input wire line_vec_t rise_en_i,
    input wire line_vec_t fall_en_i,
    input wire line_vec_t int_en_i,
    input wire line_vec_t evt_en_i,
    input wire line_vec_t pending_clear_i,
    input wire line_vec_t pending_o,
    input wire line_vec_t irq_o,
    input wire line_vec_t event_o,
    input wire logic wake_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_idle_after_rst: assert property ($rose(rstn_i) |-> !wake_o && (pending_o | irq_o) == '0)
        else $error("outputs busy after reset");
    a_irq_from_pend: assert property (irq_o == ($past(pending_o) & $past(int_en_i)))
        else $error("irq differs from pending");
    a_pend_sticky: assert property (($past(pending_o) & ~$past(pending_clear_i) & ~pending_o) == '0)
        else $error("pending dropped without clear");
    a_pend_masked: assert property ((pending_o & ~$past(pending_o) & ~$past(int_en_i)) == '0)
        else $error("pending set while masked");
    a_event_masked: assert property ((event_o & ~$past(evt_en_i)) == '0)
        else $error("event while masked");
    a_event_single: assert property ((event_o & $past(event_o)
        & ~(($past(rise_en_i, 2) | $past(rise_en_i, 3))
        & ($past(fall_en_i, 2) | $past(fall_en_i, 3)))) == '0)
        else $error("event longer than a cycle");
    a_wake_any: assert property (wake_o == |(irq_o | event_o))
        else $error("wake differs from requests");
    a_event_pend: assert property ((event_o & $past(int_en_i, 2) & ~$past(pending_o)) == '0)
        else $error("event without pending");
    c_irq: cover property (|irq_o);
    c_event: cover property (|event_o);
    c_clear: cover property (|(pending_clear_i & pending_o));
endmodule
bind event_line_ctrl event_line_ctrl_chk chk (.*);

// *** verification/event_line_ctrl_tb.sv ***
// Purpose: Self-checking bench for event_line_ctrl
// Assumes: Sources come from eel_src_model
// Notes: Pin p*16+n feeds line n through its port select
`timescale 1ns/100ps
module event_line_ctrl_tb;
    import eel_pkg::*;
    logic sys_clk_i, rstn_i, set, val, supply_low_i, cal_alarm_i, aux_event_i, wake_o;
    logic [6:0] idx;
    int_src_t src;
    pin_vec_t gpio_pins_i;
    sel_bus_t port_sel_i;
    line_vec_t rise_en_i, fall_en_i, int_en_i, evt_en_i, pending_clear_i;
    line_vec_t pending_o, irq_o, event_o;
    int errors = 0, n_tests = 0, cyc = 0, n_ev = 0;
    event_line_ctrl uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .gpio_pins_i(gpio_pins_i),
        .supply_low_i(supply_low_i), .cal_alarm_i(cal_alarm_i), .aux_event_i(aux_event_i),
        .port_sel_i(port_sel_i), .rise_en_i(rise_en_i), .fall_en_i(fall_en_i),
        .int_en_i(int_en_i), .evt_en_i(evt_en_i), .pending_clear_i(pending_clear_i),
        .pending_o(pending_o), .irq_o(irq_o), .event_o(event_o), .wake_o(wake_o));
    eel_src_model model (.sys_clk_i(sys_clk_i), .set_i(set), .idx_i(idx), .val_i(val),
        .src_i(src), .gpio_pins_o(gpio_pins_i),
        .int_src_o({aux_event_i, cal_alarm_i, supply_low_i}));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        n_ev <= n_ev + $countones(event_o);
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic drive(input logic [6:0] i, input logic v, input int gap);
        set <= 1'b1;
        idx <= i;
        val <= v;
        step(1);
        // A zero gap keeps the strobe up for a back-to-back request
        if (gap > 0) begin
            set <= 1'b0;
            step(gap);
        end
    endtask
    task automatic clear(input line_vec_t m);
        pending_clear_i <= m;
        step(1);
        pending_clear_i <= '0;
        step(2);
    endtask
    task automatic t_rise_port();
        int e0;
        e0 = n_ev;
        drive(7'h03, 1'b1, 6);
        check("irq", 32'h8, irq_o);
        check("wake", 32'h1, wake_o);
        drive(7'h03, 1'b0, 6);
        check("events", e0 + 1, n_ev);
        clear(19'h00008);
        check("pend", 32'h0, pending_o);
        port_sel_i <= 64'h0000000000000600;
        drive(7'h02, 1'b1, 6);
        drive(7'h62, 1'b1, 6);
        check("pend", 32'h4, pending_o);
        clear('1);
    endtask
    task automatic t_edges_mask();
        int e0;
        e0 = n_ev;
        for (int i = 5; i < 8; i++) drive(7'(i), 1'b1, 6);
        check("pend", 32'h40, pending_o);
        for (int i = 5; i < 8; i++) drive(7'(i), 1'b0, 6);
        check("pend", 32'h60, pending_o);
        check("events", e0 + 3, n_ev);
        clear('1);
        src <= 3'h3;
        step(7);
        check("pend", 32'h30000, pending_o);
        src <= 3'h0;
        step(7);
        check("events", e0 + 6, n_ev);
        clear('1);
    endtask
    task automatic t_port_sel();
        int e0;
        e0 = n_ev;
        drive(7'h66, 1'b1, 6);
        port_sel_i <= 64'h0000000006000600;
        step(6);
        check("pend", 32'h0, pending_o);
        port_sel_i <= 64'h000000000f000600;
        step(6);
        drive(7'h66, 1'b0, 6);
        drive(7'h06, 1'b1, 6);
        check("pend", 32'h0, pending_o);
        check("events", e0, n_ev);
    endtask
    task automatic t_narrow(input logic race, input logic [31:0] exp);
        drive(7'h09, 1'b1, 0);
        drive(7'h09, 1'b0, 1);
        pending_clear_i <= {9'h0, race, 9'h0};
        step(1);
        pending_clear_i <= '0;
        step(4);
        check("pend", exp, pending_o);
    endtask
    initial begin
        {rstn_i, set, val, idx, src, pending_clear_i, port_sel_i} = '0;
        rise_en_i = 19'h302cc;
        fall_en_i = 19'h10060;
        int_en_i = 19'h7ff7f;
        evt_en_i = 19'h7ff7f;
        step(5);
        rstn_i <= 1'b1;
        step(4);
        t_rise_port();
        t_edges_mask();
        t_port_sel();
        t_narrow(1'b0, 32'h200);
        t_narrow(1'b1, 32'h200);
        clear('1);
        check("pend", 32'h0, pending_o);
        check("irq", 32'h0, irq_o);
        check("wake", 32'h0, wake_o);
        conclude();
    end
endmodule
